// ---- pkg/dac_cal_pkg.sv ----
// Constants and types for the multichannel DAC calibration datapath.
// Assumes a single clock domain; no timescale in packages.
package dac_cal_pkg;
    // =====================================================================
    // Destination select codes of the two-bit routing field
    typedef enum logic [1:0] {
        DEST_SFR    = 2'b00,
        DEST_GAIN   = 2'b01,
        DEST_OFFSET = 2'b10,
        DEST_INPUT  = 2'b11
    } dest_sel_t;

    // =====================================================================
    // Variant defaults
    localparam int RES_BITS_14  = 14;
    localparam int RES_BITS_12  = 12;
    localparam int NUM_CH_16    = 16;
    localparam int NUM_CH_8     = 8;

    // =====================================================================
    // Reset values for the 14-bit and 12-bit resolutions
    localparam logic [13:0] GAIN_RST_14   = 14'h3ffe;
    localparam logic [13:0] OFFSET_RST_14 = 14'h2000;
    localparam logic [11:0] GAIN_RST_12   = 12'hffe;
    localparam logic [11:0] OFFSET_RST_12 = 12'h800;
    localparam logic [13:0] INPUT_RST     = 14'h0000;

    // =====================================================================
    // Interface state codes
    typedef enum logic [1:0] {
        IF_IDLE   = 2'b00,
        IF_ACTIVE = 2'b01
    } if_state_t;
endpackage : dac_cal_pkg

// ---- hdl/dac_cal_lane.sv ----
// One calibration lane: code*(gain+2)/2^n + offset - 2^(n-1), saturated.
// Assumes coefficients are already held by the caller.
`timescale 1ns/1ps
module dac_cal_lane #(
    parameter int RES = 14
) (
    // Operands
    input  wire logic [RES-1:0] code_i,
    input  wire logic [RES-1:0] gain_i,
    input  wire logic [RES-1:0] offset_i,
    // Result
    output logic      [RES-1:0] result_o
);
    import dac_cal_pkg::*;

    localparam int PW = 2*RES + 2;

    logic [PW-1:0]  prod;
    logic signed [RES+2:0] sum;
    logic [RES+1:0] scaled;

    // Multiply, scale, add signed offset and clamp
    always_comb begin
        prod   = {2'b00, code_i} * {1'b0, gain_i} + {1'b0, code_i, 1'b0};
        scaled = prod[RES +: RES+2];
        sum    = $signed({1'b0, scaled}) + $signed({3'b000, offset_i})
                 - $signed({3'b001, {(RES-1){1'b0}}}) + $signed({(RES+3){1'b0}});
        if (sum < 0) begin
            result_o = '0;
        end else if (sum > $signed({3'b000, {RES{1'b1}}})) begin
            result_o = '1;
        end else begin
            result_o = sum[RES-1:0];
        end
    end
endmodule : dac_cal_lane

// ---- hdl/dac_chan_regs.sv ----
// Per-channel register bank: input code, gain, offset, converter latch.
// Assumes write strobes are one-cycle pulses from the decoder.
`timescale 1ns/1ps
module dac_chan_regs #(
    parameter int RES = 14
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           nrst_i,
    // Writes
    input  wire logic           wr_input_i,
    input  wire logic           wr_gain_i,
    input  wire logic           wr_offset_i,
    input  wire logic [RES-1:0] data_i,
    input  wire logic           load_i,
    // State
    output logic      [RES-1:0] code_o,
    output logic      [RES-1:0] gain_o,
    output logic      [RES-1:0] offset_o,
    output logic      [RES-1:0] dac_o
);
    import dac_cal_pkg::*;

    localparam logic [RES-1:0] G_RST = (RES == 14) ? GAIN_RST_14[RES-1:0]
                                                   : {{(RES-12){1'b0}}, GAIN_RST_12};
    localparam logic [RES-1:0] O_RST = (RES == 14) ? OFFSET_RST_14[RES-1:0]
                                                   : {{(RES-12){1'b0}}, OFFSET_RST_12};

    logic [RES-1:0] code_ff, gain_ff, offset_ff, dac_ff;
    logic [RES-1:0] nxt_code, nxt_gain, nxt_offset, nxt_dac;
    logic [RES-1:0] cal;

    dac_cal_lane #(.RES(RES)) u_lane (
        .code_i   (code_ff),
        .gain_i   (gain_ff),
        .offset_i (offset_ff),
        .result_o (cal)
    );

    // Next values of the bank
    always_comb begin
        nxt_code   = wr_input_i  ? data_i : code_ff;
        nxt_gain   = wr_gain_i   ? {data_i[RES-1:1], 1'b0} : gain_ff;
        nxt_offset = wr_offset_i ? data_i : offset_ff;
        nxt_dac    = load_i      ? cal    : dac_ff;
    end

    // Bank registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            code_ff   <= INPUT_RST[RES-1:0];
            gain_ff   <= G_RST;
            offset_ff <= O_RST;
            dac_ff    <= '0;
        end else begin
            code_ff   <= nxt_code;
            gain_ff   <= nxt_gain;
            offset_ff <= nxt_offset;
            dac_ff    <= nxt_dac;
        end
    end

    // Register views
    assign code_o   = code_ff;
    assign gain_o   = gain_ff;
    assign offset_o = offset_ff;
    assign dac_o    = dac_ff;

    // Gain LSB never leaves zero
    property p_gain_lsb;
        @(posedge clk_i) disable iff (!nrst_i)
        gain_ff[0] == 1'b0;
    endproperty
    a_gain_lsb: assert property (p_gain_lsb) else $error("gain lsb not zero");
endmodule : dac_chan_regs

// ---- hdl/dac_cal_top.sv ----
// Multichannel DAC calibration and decode datapath.
// Assumes the host presents decoded words (channel, select, data) in clk_i domain.
// Function
// - Output equals code*(gain+2)/2^n plus offset-2^(n-1)
// - Gain resets to all ones, LSB zero
// - Gain LSB always held at zero
// - Offset resets to mid-code
// - Resolution n is 14 or 12
// - Select field routes data to destination
// - Input code is unsigned straight binary
// - Offset coefficient is offset binary
// - Gain coefficient is fractional multiplier
// - Each channel keeps independent coefficients
// - All channels update together on load
// - Interface idles until frame sync falls
// - Interface protocol chosen by select input
// - Sixteen or eight channels per variant
// - Internal data path n bits wide
`timescale 1ns/1ps
module dac_cal_top #(
    parameter int RES    = dac_cal_pkg::RES_BITS_14,
    parameter int NUM_CH = dac_cal_pkg::NUM_CH_16
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    // Interface control
    input  wire logic                      spi_sel_i,
    input  wire logic                      frame_sync_n_i,
    // Decoded write word
    input  wire logic                      wr_valid_i,
    input  wire logic [3:0]                wr_chan_i,
    input  wire logic                      dest_select_hi_i,
    input  wire logic                      dest_select_lo_i,
    input  wire logic [RES-1:0]            wr_data_i,
    // Load strobe
    input  wire logic                      load_strobe_n_i,
    // Special function register path
    output logic                           sfr_wr_o,
    output logic [RES-1:0]                 sfr_data_o,
    output logic [3:0]                     sfr_addr_o,
    // Interface status
    output logic                           if_active_o,
    output logic                           spi_mode_o,
    // Converter codes, channel k at [k*RES +: RES]
    output logic [NUM_CH*RES-1:0]          dac_code_o
);
    import dac_cal_pkg::*;

    // =====================================================================
    // Elaboration checks
    generate
        if (RES != RES_BITS_14 && RES != RES_BITS_12) begin : g_bad_res
            $error("RES must be 14 or 12");
        end
        if (NUM_CH != NUM_CH_16 && NUM_CH != NUM_CH_8) begin : g_bad_ch
            $error("NUM_CH must be 16 or 8");
        end
    endgenerate

    // =====================================================================
    // Interface activity and mode
    if_state_t state_ff, nxt_state;
    logic      sync_d_ff, nxt_sync_d;
    logic      mode_ff, nxt_mode;
    logic      sync_fall;

    // Wake on falling frame sync, sleep when it rises
    always_comb begin
        sync_fall  = sync_d_ff && !frame_sync_n_i;
        nxt_sync_d = frame_sync_n_i;
        nxt_state  = state_ff;
        nxt_mode   = mode_ff;
        case (state_ff)
            IF_IDLE: begin
                if (sync_fall) begin
                    nxt_state = IF_ACTIVE;
                    nxt_mode  = spi_sel_i;
                end
            end
            IF_ACTIVE: begin
                if (frame_sync_n_i) begin
                    nxt_state = IF_IDLE;
                end
            end
            default: nxt_state = IF_IDLE;
        endcase
    end

    // Interface state registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_ff  <= IF_IDLE;
            sync_d_ff <= 1'b1;
            mode_ff   <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            sync_d_ff <= nxt_sync_d;
            mode_ff   <= nxt_mode;
        end
    end

    // Status views
    assign if_active_o = (state_ff == IF_ACTIVE);
    assign spi_mode_o  = mode_ff;

    // =====================================================================
    // Destination decode
    dest_sel_t      dest;
    logic           wr_take;
    logic [NUM_CH-1:0] wr_in, wr_gn, wr_of;
    logic           load_d_ff, nxt_load_d;
    logic           load_pulse;
    logic           sfr_wr_ff, nxt_sfr_wr;
    logic [RES-1:0] sfr_data_ff, nxt_sfr_data;
    logic [3:0]     sfr_addr_ff, nxt_sfr_addr;

    // Route by select field and channel address
    always_comb begin
        dest    = dest_sel_t'({dest_select_hi_i, dest_select_lo_i});
        wr_take = wr_valid_i && (state_ff == IF_ACTIVE);
        wr_in   = '0;
        wr_gn   = '0;
        wr_of   = '0;
        nxt_sfr_wr   = 1'b0;
        nxt_sfr_data = sfr_data_ff;
        nxt_sfr_addr = sfr_addr_ff;
        if (wr_take) begin
            case (dest)
                DEST_INPUT:  if (wr_chan_i < NUM_CH) wr_in[wr_chan_i] = 1'b1;
                DEST_OFFSET: if (wr_chan_i < NUM_CH) wr_of[wr_chan_i] = 1'b1;
                DEST_GAIN:   if (wr_chan_i < NUM_CH) wr_gn[wr_chan_i] = 1'b1;
                DEST_SFR: begin
                    nxt_sfr_wr   = 1'b1;
                    nxt_sfr_data = wr_data_i;
                    nxt_sfr_addr = wr_chan_i;
                end
                default: nxt_sfr_wr = 1'b0;
            endcase
        end
        nxt_load_d = load_strobe_n_i;
        load_pulse = load_d_ff && !load_strobe_n_i;
    end

    // Decode output registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            load_d_ff   <= 1'b1;
            sfr_wr_ff   <= 1'b0;
            sfr_data_ff <= '0;
            sfr_addr_ff <= 4'h0;
        end else begin
            load_d_ff   <= nxt_load_d;
            sfr_wr_ff   <= nxt_sfr_wr;
            sfr_data_ff <= nxt_sfr_data;
            sfr_addr_ff <= nxt_sfr_addr;
        end
    end

    // Special function register outputs
    assign sfr_wr_o   = sfr_wr_ff;
    assign sfr_data_o = sfr_data_ff;
    assign sfr_addr_o = sfr_addr_ff;

    // =====================================================================
    // Channel banks
    genvar k;
    generate
        for (k = 0; k < NUM_CH; k++) begin : g_ch
            dac_chan_regs #(.RES(RES)) u_ch (
                .clk_i       (clk_i),
                .nrst_i      (nrst_i),
                .wr_input_i  (wr_in[k]),
                .wr_gain_i   (wr_gn[k]),
                .wr_offset_i (wr_of[k]),
                .data_i      (wr_data_i),
                .load_i      (load_pulse),
                .code_o      (),
                .gain_o      (),
                .offset_o    (),
                .dac_o       (dac_code_o[k*RES +: RES])
            );
        end
    endgenerate

    // =====================================================================
    // Checks
    property p_no_wake_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == IF_IDLE && !sync_fall) |=> (state_ff == IF_IDLE);
    endproperty
    a_no_wake_idle: assert property (p_no_wake_idle) else $error("woke without sync");

    property p_wake;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == IF_IDLE && sync_fall) |=> (if_active_o && spi_mode_o == $past(spi_sel_i));
    endproperty
    a_wake: assert property (p_wake) else $error("wake or mode wrong");

    property p_sfr;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_SFR) |=> (sfr_wr_o && sfr_data_o == $past(wr_data_i));
    endproperty
    a_sfr: assert property (p_sfr) else $error("sfr route wrong");

    property p_sfr_only;
        @(posedge clk_i) disable iff (!nrst_i)
        (sfr_wr_o) |-> $past(wr_take && dest == DEST_SFR);
    endproperty
    a_sfr_only: assert property (p_sfr_only) else $error("spurious sfr write");

    property p_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (!load_pulse) |=> $stable(dac_code_o);
    endproperty
    a_hold: assert property (p_hold) else $error("dac moved without load");

    property p_ch0_gain;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_gn[0] == 1'b0) |=> (g_ch[0].u_ch.gain_o == $past(g_ch[0].u_ch.gain_o));
    endproperty
    a_ch0_gain: assert property (p_ch0_gain) else $error("ch0 gain changed");

    property p_one_hot;
        @(posedge clk_i) disable iff (!nrst_i)
        $onehot0(wr_in | wr_gn | wr_of);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("multi write");

    property p_idle_no_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == IF_IDLE) |-> ((wr_in | wr_gn | wr_of) == '0);
    endproperty
    a_idle_no_write: assert property (p_idle_no_write) else $error("write while idle");

    // =====================================================================
    // Interface checks
    property p_sleep;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == IF_ACTIVE && frame_sync_n_i) |=> (state_ff == IF_IDLE);
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep on sync rise");

    property p_stay;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_ff == IF_ACTIVE && !frame_sync_n_i) |=> if_active_o;
    endproperty
    a_stay: assert property (p_stay) else $error("left active in frame");

    property p_mode_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        !(state_ff == IF_IDLE && sync_fall) |=> $stable(spi_mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved mid frame");

    property p_take_valid;
        @(posedge clk_i) disable iff (!nrst_i)
        ((wr_in | wr_gn | wr_of) != '0) |-> (wr_valid_i && if_active_o);
    endproperty
    a_take_valid: assert property (p_take_valid) else $error("write without valid");

    // =====================================================================
    // Routing checks
    property p_in_route;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_INPUT) |-> (wr_in == (NUM_CH'(1) << wr_chan_i));
    endproperty
    a_in_route: assert property (p_in_route) else $error("input route wrong");

    property p_of_route;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_OFFSET) |-> (wr_of == (NUM_CH'(1) << wr_chan_i));
    endproperty
    a_of_route: assert property (p_of_route) else $error("offset route wrong");

    property p_gn_route;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_GAIN) |-> (wr_gn == (NUM_CH'(1) << wr_chan_i));
    endproperty
    a_gn_route: assert property (p_gn_route) else $error("gain route wrong");

    property p_sfr_no_chan;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_SFR) |-> ((wr_in | wr_gn | wr_of) == '0);
    endproperty
    a_sfr_no_chan: assert property (p_sfr_no_chan) else $error("sfr hit a channel");

    property p_sfr_addr;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_take && dest == DEST_SFR) |=> (sfr_addr_o == $past(wr_chan_i));
    endproperty
    a_sfr_addr: assert property (p_sfr_addr) else $error("sfr address wrong");

    property p_sfr_keep;
        @(posedge clk_i) disable iff (!nrst_i)
        !(wr_take && dest == DEST_SFR) |=> ($stable(sfr_data_o) && $stable(sfr_addr_o));
    endproperty
    a_sfr_keep: assert property (p_sfr_keep) else $error("sfr outputs moved");

    // =====================================================================
    // Channel bank checks
    property p_code_write;
        @(posedge clk_i) disable iff (!nrst_i)
        wr_in[0] |=> (g_ch[0].u_ch.code_o == $past(wr_data_i));
    endproperty
    a_code_write: assert property (p_code_write) else $error("code not stored");

    property p_gain_write;
        @(posedge clk_i) disable iff (!nrst_i)
        wr_gn[1] |=> (g_ch[1].u_ch.gain_o == {$past(wr_data_i[RES-1:1]), 1'b0});
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain not stored");

    property p_offset_write;
        @(posedge clk_i) disable iff (!nrst_i)
        wr_of[3] |=> (g_ch[3].u_ch.offset_o == $past(wr_data_i));
    endproperty
    a_offset_write: assert property (p_offset_write) else $error("offset not stored");

    property p_last_offset;
        @(posedge clk_i) disable iff (!nrst_i)
        !wr_of[NUM_CH-1] |=> $stable(g_ch[NUM_CH-1].u_ch.offset_o);
    endproperty
    a_last_offset: assert property (p_last_offset) else $error("last offset changed");

    property p_ch0_code_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        !wr_in[0] |=> $stable(g_ch[0].u_ch.code_o);
    endproperty
    a_ch0_code_hold: assert property (p_ch0_code_hold) else $error("ch0 code changed");

    property p_ch0_load;
        @(posedge clk_i) disable iff (!nrst_i)
        load_pulse |=> (dac_code_o[RES-1:0] == $past(g_ch[0].u_ch.cal));
    endproperty
    a_ch0_load: assert property (p_ch0_load) else $error("ch0 not loaded");

    property p_last_load;
        @(posedge clk_i) disable iff (!nrst_i)
        load_pulse |=> (dac_code_o[NUM_CH*RES-1 -: RES] == $past(g_ch[NUM_CH-1].u_ch.cal));
    endproperty
    a_last_load: assert property (p_last_load) else $error("last channel not loaded");
endmodule : dac_cal_top

// ---- tb/host_word_model.sv ----
// Host model: opens frames and presents decoded write words.
// Assumes the datapath samples its inputs on the rising edge of clk_i.
`timescale 1ns/1ps
module host_word_model #(
    parameter int RES = 14
) (
    // Clock
    input  wire logic           clk_i,
    // Word outputs
    output logic                spi_sel_o,
    output logic                frame_sync_n_o,
    output logic                wr_valid_o,
    output logic      [3:0]     wr_chan_o,
    output logic                dest_select_hi_o,
    output logic                dest_select_lo_o,
    output logic      [RES-1:0] wr_data_o
);
    // =====================================================================
    // Idle levels at time zero
    initial begin
        spi_sel_o        = 1'b1;
        frame_sync_n_o   = 1'b1;
        wr_valid_o       = 1'b0;
        wr_chan_o        = 4'h0;
        {dest_select_hi_o, dest_select_lo_o} = 2'b00;
        wr_data_o        = '0;
    end

    // Select level set with the sync fall; high SPI, low I2C
    task frame_open(input logic spi);
        @(posedge clk_i);
        #1;
        spi_sel_o      = spi;
        frame_sync_n_o = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : frame_open

    // End of frame
    task frame_close();
        @(posedge clk_i);
        #1;
        frame_sync_n_o = 1'b1;
    endtask : frame_close

    // One word, valid for a single cycle; data inverted once released
    task send(input logic [3:0] ch, input logic [1:0] sel, input logic [RES-1:0] d);
        @(posedge clk_i);
        #1;
        wr_chan_o  = ch;
        {dest_select_hi_o, dest_select_lo_o} = sel;
        wr_data_o  = d;
        wr_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_valid_o = 1'b0;
        wr_data_o  = ~d;
    endtask : send
endmodule : host_word_model

// ---- tb/test_dac_code_calibration_datapath.sv ----
// Testbench of the calibration datapath, 14-bit 16-channel build.
// Assumes the host model drives the word ports; the bench drives load.
`timescale 1ns/1ps
module test_dac_code_calibration_datapath;
    import dac_cal_pkg::*;
    localparam int RES = 14;
    logic            clk = 1'b0, nrst_n = 1'b0, ld_n = 1'b1;
    logic            spi_sel, fs_n, wr_valid, sel_hi, sel_lo;
    logic [3:0]      wr_chan, sfr_addr;
    logic [RES-1:0]  wr_data, sfr_data;
    logic            sfr_wr, if_active, spi_mode;
    logic [16*RES-1:0] dac;
    int              num_errors = 0;
    int              n_compared = 0;

    // =====================================================================
    // Clock and instances
    always #20 clk = ~clk;
    host_word_model #(.RES(RES)) i_host (.clk_i(clk), .spi_sel_o(spi_sel),
        .frame_sync_n_o(fs_n), .wr_valid_o(wr_valid), .wr_chan_o(wr_chan),
        .dest_select_hi_o(sel_hi), .dest_select_lo_o(sel_lo), .wr_data_o(wr_data));
    dac_cal_top #(.RES(RES), .NUM_CH(16)) i_dut (.clk_i(clk), .nrst_i(nrst_n),
        .spi_sel_i(spi_sel), .frame_sync_n_i(fs_n), .wr_valid_i(wr_valid),
        .wr_chan_i(wr_chan), .dest_select_hi_i(sel_hi), .dest_select_lo_i(sel_lo),
        .wr_data_i(wr_data), .load_strobe_n_i(ld_n), .sfr_wr_o(sfr_wr),
        .sfr_data_o(sfr_data), .sfr_addr_o(sfr_addr), .if_active_o(if_active),
        .spi_mode_o(spi_mode), .dac_code_o(dac));

    // =====================================================================
    // Shared tasks
    task chk(input string nm, input logic [RES-1:0] seen, input logic [RES-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [RES-1:0] calc(input logic [RES-1:0] code, gain, offs);
        longint v;
        v = (longint'(code) * (longint'(gain) + 2)) >>> 14;
        v = v + longint'(offs) - 8192;
        if (v < 0) v = 0;
        if (v > 16383) v = 16383;
        return v[RES-1:0];
    endfunction : calc

    function automatic logic [RES-1:0] ch(input int k);
        return dac[k*RES +: RES];
    endfunction : ch

    // Falling strobe, then let the update land
    task pulse_load();
        @(posedge clk);
        #1 ld_n = 1'b0;
        @(posedge clk);
        #1 ld_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse_load

    task stop_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    // =====================================================================
    // Scenarios
    task t_reset_idle();
        for (int k = 0; k < 16; k++) chk("dac reset", ch(k), 14'h0000);
        chk("spi_mode reset", {13'h0000, spi_mode}, 14'h0001);
        chk("active reset", {13'h0000, if_active}, 14'h0000);
        i_host.send(4'h5, 2'b11, 14'h0abc);
        pulse_load();
        chk("idle write dropped", ch(5), 14'h0000);
    endtask : t_reset_idle

    task t_defaults();
        i_host.frame_open(1'b1);
        #1 chk("active", {13'h0000, if_active}, 14'h0001);
        i_host.send(4'h0, 2'b11, 14'h1234);
        repeat (3) @(posedge clk);
        #1 chk("held until load", ch(0), 14'h0000);
        pulse_load();
        chk("default coeffs", ch(0), calc(14'h1234, 14'h3ffe, 14'h2000));
    endtask : t_defaults

    task t_gain();
        logic [RES-1:0] g[4] = '{14'h2ffe, 14'h1ffe, 14'h0ffe, 14'h0000};
        i_host.send(4'h1, 2'b01, 14'h2001);
        i_host.send(4'h1, 2'b11, 14'h3fff);
        i_host.send(4'h2, 2'b11, 14'h3fff);
        for (int k = 0; k < 4; k++) begin
            i_host.send(4'(6 + k), 2'b01, g[k]);
            i_host.send(4'(6 + k), 2'b11, 14'h3fff);
        end
        pulse_load();
        chk("gain lsb", ch(1), calc(14'h3fff, 14'h2000, 14'h2000));
        chk("other chan", ch(2), 14'h3fff);
        for (int k = 0; k < 4; k++)
            chk("gain step", ch(6 + k), calc(14'h3fff, g[k], 14'h2000));
    endtask : t_gain

    task t_offset();
        i_host.send(4'h3, 2'b10, 14'h3fff);
        i_host.send(4'h3, 2'b11, 14'h3fff);
        i_host.send(4'h4, 2'b10, 14'h0000);
        i_host.send(4'h4, 2'b11, 14'h0100);
        i_host.send(4'h5, 2'b10, 14'h2001);
        i_host.send(4'h5, 2'b11, 14'h0000);
        pulse_load();
        chk("clamp high", ch(3), 14'h3fff);
        chk("clamp low", ch(4), 14'h0000);
        chk("plus one", ch(5), 14'h0001);
        chk("kept", ch(0), 14'h1234);
    endtask : t_offset

    task t_sfr_mode();
        int i;
        i = 0;
        i_host.send(4'h7, 2'b00, 14'h1555);
        while (sfr_wr !== 1'b1 && i < 4) begin
            @(posedge clk);
            #1 i++;
        end
        chk("sfr strobe", {13'h0000, sfr_wr}, 14'h0001);
        chk("sfr data", sfr_data, 14'h1555);
        chk("sfr addr", {10'h000, sfr_addr}, 14'h0007);
        i_host.frame_close();
        repeat (3) @(posedge clk);
        #1 chk("back idle", {13'h0000, if_active}, 14'h0000);
        i_host.frame_open(1'b0);
        #1 chk("i2c mode", {13'h0000, spi_mode}, 14'h0000);
        i_host.frame_close();
        i_host.frame_open(1'b1);
        #1 chk("spi mode", {13'h0000, spi_mode}, 14'h0001);
        i_host.frame_close();
    endtask : t_sfr_mode

    // =====================================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst_n = 1'b1;
        t_reset_idle();
        t_defaults();
        t_gain();
        t_offset();
        t_sfr_mode();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule : test_dac_code_calibration_datapath
